// ==== logic/ast_start_ctrl.sv ====
// Purpose: Start, stop and trigger control of the converter, with the
//   converter clock enable, behind an AXI4-Lite register slave.
// Assumes: Engine strobes are on clk_sys; trigger pins are asynchronous.
// Notes: Injected conversions take priority; a normal start waits for them.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module ast_start_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger,
  input wire logic inj_trigger,
  input wire logic chain_done,
  input wire logic inj_done,
  output logic chain_go,
  output logic inj_go,
  output logic conv_clk_en
);
  import ast_pkg::*;

  ast_cfg_s cfg_q;
  ast_nstate_e nstate_q;
  logic stop_q;
  logic jbusy_q;
  logic clk_div_q;
  logic chain_go_q;
  logic inj_go_q;
  logic conv_clk_en_q;
  logic [3:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_do;
  logic wr_cfg;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic normal_start_wr1;
  logic normal_start_wr0;
  logic injection_start_wr1;
  logic ext_req;
  logic inj_ext_req;
  logic n_req;
  logic j_req;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;

  // Byte-lane mask and the new value of the configuration word.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wstrb_q[i]}};
    end
    wval = (cfg_word & ~wmask) | (wdata_q & wmask);
  end

  // A write is carried out once address and data are both held.
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_cfg = wr_do & (awaddr_q == AST_CFG_ADDR);
  assign normal_start_wr1 = wr_cfg & wstrb_q[0] & wdata_q[AST_B_NORMAL_START];
  assign normal_start_wr0 = wr_cfg & wstrb_q[0] & ~wdata_q[AST_B_NORMAL_START];
  assign injection_start_wr1 = wr_cfg & wstrb_q[1] & wdata_q[AST_B_INJECTION_START];

  // Trigger detectors for the normal and injected start pins.
  ast_trig_det u_norm_trig (
    .clk_sys(clk_sys),
    .reset(reset),
    .trig_pin(ext_trigger),
    .enable(cfg_q.trg_en),
    .level_mode(cfg_q.trigger_edge_or_level_select),
    .high_sel(cfg_q.edge_sel),
    .req(ext_req)
  );

  ast_trig_det u_inj_trig (
    .clk_sys(clk_sys),
    .reset(reset),
    .trig_pin(inj_trigger),
    .enable(cfg_q.jtrg_en),
    .level_mode(1'b0),
    .high_sel(cfg_q.injection_edge_select),
    .req(inj_ext_req)
  );

  // Start requests; none is raised while powered down.
  assign n_req = ~cfg_q.pwr_down & (normal_start_wr1 | ext_req);
  assign j_req = ~cfg_q.pwr_down & (injection_start_wr1 | inj_ext_req);

  // Configuration fields; reserved positions 6 and 14 are stored too.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_q <= '0;
      cfg_q.pwr_down <= AST_RST_PWR_DOWN;
    end else if (wr_cfg) begin
      cfg_q.pwr_down <= wval[AST_B_PWR_DOWN];
      cfg_q.scan <= wval[AST_B_SCAN];
      cfg_q.trg_en <= wval[AST_B_TRG_EN];
      cfg_q.trigger_edge_or_level_select <= wval[AST_B_TRIGGER_EDGE_OR_LEVEL_SELECT];
      cfg_q.edge_sel <= wval[AST_B_EDGE];
      cfg_q.rsv6 <= wval[AST_B_RSV6];
      cfg_q.jtrg_en <= wval[AST_B_JTRG_EN];
      cfg_q.injection_edge_select <= wval[AST_B_INJECTION_EDGE_SELECT];
      cfg_q.rsv14 <= wval[AST_B_RSV14];
      if (cfg_q.pwr_down) begin
        cfg_q.clk_sel <= wval[AST_B_CLK_SEL];
      end
    end
  end

  // Injected conversion: busy from start until the engine reports done.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jbusy_q <= 1'b0;
      inj_go_q <= 1'b0;
    end else begin
      inj_go_q <= j_req & ~jbusy_q;
      if (j_req & ~jbusy_q) begin
        jbusy_q <= 1'b1;
      end else if (inj_done) begin
        jbusy_q <= 1'b0;
      end
    end
  end

  // Normal chain and scan sequencer, held pending behind injection.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nstate_q <= AST_N_IDLE;
      stop_q <= 1'b0;
      chain_go_q <= 1'b0;
    end else begin
      chain_go_q <= 1'b0;
      unique case (nstate_q)
        AST_N_IDLE: begin
          stop_q <= 1'b0;
          if (n_req) begin
            nstate_q <= AST_N_PEND;
          end
        end
        AST_N_PEND: begin
          if (normal_start_wr0) begin
            nstate_q <= AST_N_IDLE;
          end else if (~jbusy_q & ~j_req) begin
            chain_go_q <= 1'b1;
            nstate_q <= AST_N_RUN;
          end
        end
        AST_N_RUN: begin
          if (chain_done) begin
            if (cfg_q.scan & ~stop_q & ~normal_start_wr0) begin
              nstate_q <= AST_N_PEND;
            end else begin
              nstate_q <= AST_N_IDLE;
            end
          end else if (normal_start_wr0) begin
            stop_q <= 1'b1;
          end
        end
        default: begin
          nstate_q <= AST_N_IDLE;
        end
      endcase
    end
  end

  // Converter clock enable: every cycle, or every second cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_div_q <= 1'b0;
      conv_clk_en_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
      conv_clk_en_q <= cfg_q.clk_sel | clk_div_q;
    end
  end

  // Read views of the configuration and status words.
  always_comb begin
    cfg_word = '0;
    cfg_word[AST_B_PWR_DOWN] = cfg_q.pwr_down;
    cfg_word[AST_B_SCAN] = cfg_q.scan;
    cfg_word[AST_B_TRG_EN] = cfg_q.trg_en;
    cfg_word[AST_B_TRIGGER_EDGE_OR_LEVEL_SELECT] = cfg_q.trigger_edge_or_level_select;
    cfg_word[AST_B_EDGE] = cfg_q.edge_sel;
    cfg_word[AST_B_RSV6] = cfg_q.rsv6;
    cfg_word[AST_B_NORMAL_START] = (nstate_q != AST_N_IDLE);
    cfg_word[AST_B_JTRG_EN] = cfg_q.jtrg_en;
    cfg_word[AST_B_INJECTION_EDGE_SELECT] = cfg_q.injection_edge_select;
    cfg_word[AST_B_INJECTION_START] = jbusy_q;
    cfg_word[AST_B_RSV14] = cfg_q.rsv14;
    cfg_word[AST_B_CLK_SEL] = cfg_q.clk_sel;
    stat_word = '0;
    stat_word[AST_S_NRUN] = (nstate_q == AST_N_RUN);
    stat_word[AST_S_NPEND] = (nstate_q == AST_N_PEND);
    stat_word[AST_S_JBUSY] = jbusy_q;
    stat_word[AST_S_STOP] = stop_q;
  end

  // Write address and data channels, taken in either order.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        aw_have_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid & wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        w_have_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= AST_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == AST_CFG_ADDR) ? AST_RESP_OKAY : AST_RESP_SLVERR;
    end else if (bvalid_q & s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel, answered one cycle after the address is taken.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AST_RESP_OKAY;
    end else if (s_axi_arvalid & arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      if (s_axi_araddr == AST_CFG_ADDR) begin
        rdata_q <= cfg_word;
        rresp_q <= AST_RESP_OKAY;
      end else if (s_axi_araddr == AST_STAT_ADDR) begin
        rdata_q <= stat_word;
        rresp_q <= AST_RESP_OKAY;
      end else begin
        rdata_q <= '0;
        rresp_q <= AST_RESP_SLVERR;
      end
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign chain_go = chain_go_q;
  assign inj_go = inj_go_q;
  assign conv_clk_en = conv_clk_en_q;

endmodule // ast_start_ctrl

// ==== logic/ast_pkg.sv ====
// Purpose: Shared constants and types for the converter start and trigger
//   control block.
// Assumes: One 32-bit configuration word and one status word on AXI4-Lite.
// Notes: Bit positions follow the configuration word layout.
package ast_pkg;

  // Register byte addresses.
  localparam logic [3:0] AST_CFG_ADDR = 4'h0;
  localparam logic [3:0] AST_STAT_ADDR = 4'h4;

  // Configuration word field positions.
  localparam int AST_B_PWR_DOWN = 0;
  localparam int AST_B_SCAN = 1;
  localparam int AST_B_TRG_EN = 3;
  localparam int AST_B_TRIGGER_EDGE_OR_LEVEL_SELECT = 4;
  localparam int AST_B_EDGE = 5;
  localparam int AST_B_RSV6 = 6;
  localparam int AST_B_NORMAL_START = 7;
  localparam int AST_B_JTRG_EN = 9;
  localparam int AST_B_INJECTION_EDGE_SELECT = 10;
  localparam int AST_B_INJECTION_START = 11;
  localparam int AST_B_RSV14 = 14;
  localparam int AST_B_CLK_SEL = 23;

  // Status word field positions.
  localparam int AST_S_NRUN = 0;
  localparam int AST_S_NPEND = 1;
  localparam int AST_S_JBUSY = 2;
  localparam int AST_S_STOP = 3;

  // Reset value: powered down, everything else cleared.
  localparam logic AST_RST_PWR_DOWN = 1'b1;

  // AXI responses.
  localparam logic [1:0] AST_RESP_OKAY = 2'h0;
  localparam logic [1:0] AST_RESP_SLVERR = 2'h2;

  // Normal chain sequencer states.
  typedef enum logic [1:0] {
    AST_N_IDLE = 2'b00,
    AST_N_PEND = 2'b01,
    AST_N_RUN = 2'b10
  } ast_nstate_e;

  // Stored configuration fields.
  typedef struct packed {
    logic pwr_down;
    logic scan;
    logic trg_en;
    logic trigger_edge_or_level_select;
    logic edge_sel;
    logic rsv6;
    logic jtrg_en;
    logic injection_edge_select;
    logic rsv14;
    logic clk_sel;
  } ast_cfg_s;

endpackage

// ==== logic/ast_trig_det.sv ====
// Purpose: Synchronise one trigger pin and turn it into start requests.
// Assumes: The pin is asynchronous to clk_sys.
// Notes: Level mode requests every cycle the level is present.
`timescale 1ns/1ns
module ast_trig_det (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic trig_pin,
  input wire logic enable,
  input wire logic level_mode,
  input wire logic high_sel,
  output logic req
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // Two-stage synchroniser, then one more stage for edge compare.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= trig_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Select the active edge or level of the synchronised sample.
  always_comb begin
    if (!enable) begin
      req = 1'b0;
    end else if (level_mode) begin
      req = (sync2_q == high_sel);
    end else if (high_sel) begin
      req = sync2_q & ~prev_q;
    end else begin
      req = ~sync2_q & prev_q;
    end
  end

endmodule // ast_trig_det

// ==== sim/ast_start_checker.sv ====
// Purpose: Timing checks on the ports of the start control block.
// Assumes: Bound to ast_start_ctrl; one clock domain.
// Notes: Bus checks cover answer timing and read data holding.
`timescale 1ns/1ns
module ast_start_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chain_go,
  input wire logic inj_go,
  input wire logic conv_clk_en
);
  import ast_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Engine start pulses last one cycle; injection wins over normal starts.
  property p_go_pulse; chain_go |=> !chain_go; endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("long chain go");
  property p_inj_pulse; inj_go |=> !inj_go; endproperty
  a_inj_pulse: assert property (p_inj_pulse) else $error("long inj go");
  property p_go_order; inj_go |-> !chain_go; endproperty
  a_go_order: assert property (p_go_order) else $error("both go");
  // Unused positions 8, 12, 13, 15 and 16 to 22 read zero in every word returned.
  property p_rsv_zero;
    s_axi_rvalid |-> (s_axi_rdata & 32'h007fb100) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved set");
  // Past the first cycle out of reset, the converter clock enable is never low two cycles in a row.
  property p_clk_run; !conv_clk_en && !$past(reset) |=> conv_clk_en; endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock stalled");
  // A write taken whole drops awready next cycle and is answered the cycle after.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_ans;
    s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  property p_rd_ans; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  // Read data hold until taken, then the channel frees itself.
  property p_r_hold;
    s_axi_rvalid |=> $past(s_axi_rready) ? (!s_axi_rvalid && s_axi_arready)
      : (s_axi_rvalid && $stable(s_axi_rdata));
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // ast_start_checker

// ==== sim/ast_engine_model.sv ====
// Purpose: Conversion engine stand-in answering start pulses.
// Assumes: Go pulses are one cycle on clk_sys.
// Notes: Each chain takes DLY cycles, then one done pulse.
`timescale 1ns/1ns
module ast_engine_model #(parameter int DLY = 20) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chain_go,
  input wire logic inj_go,
  output logic chain_done,
  output logic inj_done
);
  int n_cnt;
  int j_cnt;
  // Normal chain timer.
  always_ff @(posedge clk_sys) begin
    chain_done <= (n_cnt == 1);
    if (reset) n_cnt <= 0;
    else if (chain_go) n_cnt <= DLY;
    else if (n_cnt > 0) n_cnt <= n_cnt - 1;
  end
  // Injected chain timer.
  always_ff @(posedge clk_sys) begin
    inj_done <= (j_cnt == 1);
    if (reset) j_cnt <= 0;
    else if (inj_go) j_cnt <= DLY;
    else if (j_cnt > 0) j_cnt <= j_cnt - 1;
  end
endmodule // ast_engine_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the converter start control block.
// Assumes: The engine model answers every go pulse after a fixed delay.
// Notes: Registers are reached by an AXI4-Lite master task pair.
`timescale 1ns/1ns
module tb_top;
  import ast_pkg::*;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic ext_trig = 1'h0, inj_trig = 1'h0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, c_go, i_go, c_dn, i_dn, ck_en;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  int err_total = 0, tests_run = 0, cyc = 0, n_go = 0, n_done = 0, n_inj = 0;
  always #5 clk_sys = ~clk_sys;
  ast_start_ctrl dut_u (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .ext_trigger(ext_trig),
    .inj_trigger(inj_trig), .chain_done(c_dn), .inj_done(i_dn),
    .chain_go(c_go), .inj_go(i_go), .conv_clk_en(ck_en));
  ast_engine_model eng_u (.clk_sys(clk_sys), .reset(reset), .chain_go(c_go),
    .inj_go(i_go), .chain_done(c_dn), .inj_done(i_dn));
  // Counts engine traffic and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_go <= n_go + (c_go === 1'h1);
    n_done <= n_done + (c_dn === 1'h1);
    n_inj <= n_inj + (i_go === 1'h1);
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Offers address and data together, releasing each once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk_sys);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge clk_sys);
      if (!ta && aw_rdy === 1'h1) aw_v <= 1'h0;
      if (!tw && w_rdy === 1'h1) w_v <= 1'h0;
      ta = ta | (aw_rdy === 1'h1);
      tw = tw | (w_rdy === 1'h1);
    end
    do @(posedge clk_sys); while (b_v !== 1'h1);
    b_r <= 1'h0;
    chk(b_resp, r);
  endtask
  // Holds rready from the request on and takes the data at the rvalid edge.
  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clk_sys);
    ar_a <= a;
    ar_v <= 1'h1;
    r_r <= 1'h1;
    do @(posedge clk_sys); while (ar_rdy !== 1'h1);
    ar_v <= 1'h0;
    do @(posedge clk_sys); while (r_v !== 1'h1);
    r_r <= 1'h0;
    chk(r_d, d);
    chk(r_resp, r);
  endtask
  task automatic clk_cnt(input int e);
    int k;
    k = 0;
    repeat (8) begin
      @(posedge clk_sys);
      k += (ck_en === 1'h1);
    end
    chk(k, e);
  endtask
  task automatic t_regs();
    rd(AST_CFG_ADDR, 32'h1, AST_RESP_OKAY);
    wr(AST_CFG_ADDR, 32'h007fb101, AST_RESP_OKAY);
    rd(AST_CFG_ADDR, 32'h1, AST_RESP_OKAY);
    wr(4'h8, 32'h0, AST_RESP_SLVERR);
    wr(AST_STAT_ADDR, 32'h0, AST_RESP_SLVERR);
    rd(4'hc, 32'h0, AST_RESP_SLVERR);
    $display("t_regs finished");
  endtask
  task automatic t_clk();
    wr(AST_CFG_ADDR, 32'h00800001, AST_RESP_OKAY);
    rd(AST_CFG_ADDR, 32'h00800001, AST_RESP_OKAY);
    clk_cnt(8);
    wr(AST_CFG_ADDR, 32'h1, AST_RESP_OKAY);
    clk_cnt(4);
    wr(AST_CFG_ADDR, 32'h0, AST_RESP_OKAY);
    wr(AST_CFG_ADDR, 32'h00800000, AST_RESP_OKAY);
    rd(AST_CFG_ADDR, 32'h0, AST_RESP_OKAY);
    clk_cnt(4);
    $display("t_clk finished");
  endtask
  task automatic t_norm();
    int b;
    b = n_go;
    wr(AST_CFG_ADDR, 32'h80, AST_RESP_OKAY);
    rd(AST_CFG_ADDR, 32'h80, AST_RESP_OKAY);
    idle(40);
    chk(n_go - b, 1);
    rd(AST_CFG_ADDR, 32'h0, AST_RESP_OKAY);
    $display("t_norm finished");
  endtask
  task automatic t_scan();
    int b;
    int d;
    b = n_go;
    d = n_done;
    wr(AST_CFG_ADDR, 32'h82, AST_RESP_OKAY);
    while (n_go < b + 2) @(posedge clk_sys);
    wr(AST_CFG_ADDR, 32'h02, AST_RESP_OKAY);
    idle(60);
    chk(n_go - b, 2);
    chk(n_done - d, 2);
    $display("t_scan finished");
  endtask
  // Each trigger mode: idle level first, then the active level or edge.
  task automatic t_trig();
    logic [31:0] m [5] = '{32'h20, 32'h08, 32'h28, 32'h18, 32'h38};
    logic id [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    int ek [5] = '{0, 1, 1, 2, 2};
    int b;
    int d;
    for (int i = 0; i < 5; i++) begin
      ext_trig <= id[i];
      idle(8);
      b = n_go;
      wr(AST_CFG_ADDR, m[i], AST_RESP_OKAY);
      idle(8);
      ext_trig <= ~id[i];
      idle(60);
      wr(AST_CFG_ADDR, 32'h0, AST_RESP_OKAY);
      idle(40);
      d = n_go - b;
      chk(ek[i] == 2 ? (d > 1) : (d == ek[i]), 1);
    end
    ext_trig <= 1'h0;
    $display("t_trig finished");
  endtask
  task automatic inj_step(input logic v, input int e);
    inj_trig <= v;
    idle(30);
    chk(n_inj, e);
  endtask
  task automatic t_inj();
    int b;
    int c;
    b = n_inj;
    wr(AST_CFG_ADDR, 32'h400, AST_RESP_OKAY);
    inj_step(1'h1, b);
    inj_step(1'h0, b);
    wr(AST_CFG_ADDR, 32'h600, AST_RESP_OKAY);
    inj_step(1'h1, b + 1);
    inj_step(1'h0, b + 1);
    wr(AST_CFG_ADDR, 32'h200, AST_RESP_OKAY);
    inj_step(1'h1, b + 1);
    inj_step(1'h0, b + 2);
    c = n_go;
    wr(AST_CFG_ADDR, 32'h800, AST_RESP_OKAY);
    wr(AST_CFG_ADDR, 32'h80, AST_RESP_OKAY);
    rd(AST_CFG_ADDR, 32'h880, AST_RESP_OKAY);
    rd(AST_STAT_ADDR, 32'h6, AST_RESP_OKAY);
    chk(n_go - c, 0);
    idle(60);
    chk(n_inj - b, 3);
    chk(n_go - c, 1);
    $display("t_inj finished");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset, then the scenarios in order.
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    t_regs();
    t_clk();
    t_norm();
    t_scan();
    t_trig();
    t_inj();
    test_done();
  end
endmodule // tb_top
bind ast_start_ctrl ast_start_checker chk_u (.clk_sys(clk_sys),
  .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .chain_go(chain_go), .inj_go(inj_go),
  .conv_clk_en(conv_clk_en));
